// ---- inc/button_irq_defs.svh ----
`ifndef BUTTON_IRQ_DEFS_SVH
`define BUTTON_IRQ_DEFS_SVH

`define ADDR_BTN_STAT 8'h24
`define ADDR_BTN_MASK 8'h25
`define ADDR_BTN_SENSE 8'h26
`define ADDR_MISC_STAT 8'h28

`define BTN_MASK_RESET 6'h3f
`define BTN_STAT_RESET 6'h00
`define MISC_STAT_RESET 5'h00
`define MISC_MASK_RESET 5'h1f
`define RDATA_RESET 8'h00
`define BIT_PRESS 0

`define HELD1_SEC 4'h1
`define HELD2_SEC 4'h2
`define HELD3_SEC 4'h3
`define HELD4_SEC 4'h4
`define HELD8_SEC 4'h8

`define CLK_PERIOD_NS 10
`define HELD_UNIT_NS 1000000000
`define HELD_UNIT_CYCLES (`HELD_UNIT_NS / `CLK_PERIOD_NS)

`endif

// ---- inc/button_irq_pkg.sv ----
`default_nettype none
package button_irq_pkg;
    typedef enum logic [3:0]
    {
        DB_RELEASED = 4'h1,
        DB_FALL = 4'h2,
        DB_PRESSED = 4'h4,
        DB_RISE = 4'h8
    } deb_state_t;
    typedef logic [7:0] reg_byte_t;
endpackage
`default_nettype wire

// ---- design/button_and_power_event_irq.sv ----
// How it works
// - unmasked set button status bit pulls irq_out_n low
// - masked button status bit never pulls irq_out_n low
// - button mask at 0x25, press mask bit 0, all mask bits reset to 1
// - mask bits 1..5 gate held 1,2,3,4,8 s flags; bits 7..6 unused
// - press sense bit 0 reads 1 while debounced button is low
// - press sense comes through a debounce filter of programmable length
// - held sense bits 1..5 read 1 once held low beyond 1,2,3,4,8 s
// - held sense bits clear as soon as press sense returns to 0
// - sense register at 0x26 is read-only, resets to 0, bits 7..6 unused
// - misc bit 0 sets when standby or sleep to run completes
// - misc bit 1 sets when run to standby or sleep completes
// - misc bit 2 sets on a power-on button event
// - misc bit 3 sets when rail crosses the low-warning threshold
// - misc bit 4 sets on rail overvoltage crossing; bits 7..5 unused
// - misc bits clear on register read or on write of 1; 0 keeps
// - misc status at 0x28 resets to 0, flags stay set until cleared
// - press flag sets on every change of press sense
// - held flags set once held beyond the matching duration
`timescale 1ns/1ns
`default_nettype none
`include "button_irq_defs.svh"

module button_and_power_event_irq
#(
    parameter int unsigned SEC_CYCLES = `HELD_UNIT_CYCLES,
    parameter int unsigned DEB_W = 16
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic power_button_input,
    input wire logic [DEB_W-1:0] debounce_fall_cycles,
    input wire logic [DEB_W-1:0] debounce_rise_cycles,
    input wire logic [4:0] misc_event_in,
    input wire logic [4:0] misc_mask,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire button_irq_pkg::reg_byte_t reg_wdata,
    output button_irq_pkg::reg_byte_t reg_rdata,
    output logic irq_out_n
);
    import button_irq_pkg::*;

    localparam int unsigned PRE_W = $clog2(SEC_CYCLES + 1);

    function automatic logic [5:0] w1c(input logic [5:0] cur, input logic [5:0] set,
                                       input logic [5:0] clr);
        w1c = (cur & ~clr) | set;
    endfunction

    function automatic logic [4:0] held_vec(input logic [3:0] sec);
        held_vec = {sec >= `HELD8_SEC, sec >= `HELD4_SEC, sec >= `HELD3_SEC,
                    sec >= `HELD2_SEC, sec >= `HELD1_SEC};
    endfunction

    // pin and event synchronisers, first stage read only by the second
    logic btn_s1_q, btn_s2_q, btn_s1_d, btn_s2_d;
    logic [4:0] ev_s1_q, ev_s2_q, ev_s3_q, ev_s1_d, ev_s2_d, ev_s3_d;

    always_comb
    begin
        btn_s1_d = power_button_input;
        btn_s2_d = btn_s1_q;
        ev_s1_d = misc_event_in;
        ev_s2_d = ev_s1_q;
        ev_s3_d = ev_s2_q;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            btn_s1_q <= 1'b1;
            btn_s2_q <= 1'b1;
            ev_s1_q <= 5'h00;
            ev_s2_q <= 5'h00;
            ev_s3_q <= 5'h00;
        end
        else
        begin
            btn_s1_q <= btn_s1_d;
            btn_s2_q <= btn_s2_d;
            ev_s1_q <= ev_s1_d;
            ev_s2_q <= ev_s2_d;
            ev_s3_q <= ev_s3_d;
        end
    end

    logic btn_low;
    logic [4:0] misc_evt;
    assign btn_low = ~btn_s2_q;
    // event inputs are levels; a rising edge marks one event
    assign misc_evt = ev_s2_q & ~ev_s3_q;

    // debounce filter
    deb_state_t deb_q, deb_d;
    logic [DEB_W-1:0] deb_cnt_q, deb_cnt_d;
    logic press_q, press_d;

    always_comb
    begin
        deb_d = deb_q;
        deb_cnt_d = deb_cnt_q;
        case (deb_q)
            DB_RELEASED:
            begin
                deb_cnt_d = '0;
                if (btn_low)
                    deb_d = DB_FALL;
            end
            DB_FALL:
            begin
                if (!btn_low)
                    deb_d = DB_RELEASED;
                else if (deb_cnt_q >= debounce_fall_cycles)
                    deb_d = DB_PRESSED;
                else
                    deb_cnt_d = deb_cnt_q + 1'b1;
            end
            DB_PRESSED:
            begin
                deb_cnt_d = '0;
                if (!btn_low)
                    deb_d = DB_RISE;
            end
            DB_RISE:
            begin
                if (btn_low)
                    deb_d = DB_PRESSED;
                else if (deb_cnt_q >= debounce_rise_cycles)
                    deb_d = DB_RELEASED;
                else
                    deb_cnt_d = deb_cnt_q + 1'b1;
            end
            default:
            begin
                deb_d = DB_RELEASED;
                deb_cnt_d = '0;
            end
        endcase
        // a short glitch back during a pending release keeps the press
        press_d = (deb_d == DB_PRESSED) || (deb_d == DB_RISE);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            deb_q <= DB_RELEASED;
            deb_cnt_q <= '0;
            press_q <= 1'b0;
        end
        else
        begin
            deb_q <= deb_d;
            deb_cnt_q <= deb_cnt_d;
            press_q <= press_d;
        end
    end

    // held-duration timer, saturates at the longest threshold
    logic [PRE_W-1:0] pre_q, pre_d;
    logic [3:0] sec_q, sec_d;
    logic [4:0] held_q, held_d;

    always_comb
    begin
        pre_d = '0;
        sec_d = 4'h0;
        if (press_d)
        begin
            sec_d = sec_q;
            pre_d = pre_q + 1'b1;
            if (pre_q == PRE_W'(SEC_CYCLES - 1))
            begin
                pre_d = '0;
                if (sec_q < `HELD8_SEC)
                    sec_d = sec_q + 4'h1;
            end
        end
        held_d = held_vec(sec_d);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pre_q <= '0;
            sec_q <= 4'h0;
            held_q <= 5'h00;
        end
        else
        begin
            pre_q <= pre_d;
            sec_q <= sec_d;
            held_q <= held_d;
        end
    end

    // register file and interrupt pin
    logic [5:0] btn_mask_q, btn_mask_d, btn_stat_q, btn_stat_d, btn_set, btn_clr;
    logic [4:0] misc_stat_q, misc_stat_d, misc_set, misc_clr, misc_mask_q;
    logic irq_n_d;
    reg_byte_t rdata_d;
    logic [5:0] sense;

    assign sense = {held_q, press_q};

    always_comb
    begin
        btn_mask_d = btn_mask_q;
        if (reg_wr && reg_addr == `ADDR_BTN_MASK)
            btn_mask_d = reg_wdata[5:0];
        btn_set = {held_d & ~held_q, press_d != press_q};
        btn_clr = 6'h00;
        if (reg_wr && reg_addr == `ADDR_BTN_STAT)
            btn_clr = reg_wdata[5:0];
        if (reg_rd && reg_addr == `ADDR_BTN_STAT)
            btn_clr = 6'h3f;
        // set terms win over a same-cycle clear
        btn_stat_d = w1c(btn_stat_q, btn_set, btn_clr);
        misc_set = misc_evt;
        misc_clr = 5'h00;
        if (reg_wr && reg_addr == `ADDR_MISC_STAT)
            misc_clr = reg_wdata[4:0];
        if (reg_rd && reg_addr == `ADDR_MISC_STAT)
            misc_clr = 5'h1f;
        misc_stat_d = 5'(w1c({1'b0, misc_stat_q}, {1'b0, misc_set}, {1'b0, misc_clr}));
        irq_n_d = ~(|(btn_stat_d & ~btn_mask_d) | |(misc_stat_d & ~misc_mask));
        rdata_d = reg_rdata;
        if (reg_rd)
        begin
            case (reg_addr)
                `ADDR_BTN_STAT: rdata_d = {2'b00, btn_stat_q};
                `ADDR_BTN_MASK: rdata_d = {2'b00, btn_mask_q};
                `ADDR_BTN_SENSE: rdata_d = {2'b00, sense};
                `ADDR_MISC_STAT: rdata_d = {3'b000, misc_stat_q};
                default: rdata_d = `RDATA_RESET;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            btn_mask_q <= `BTN_MASK_RESET;
            btn_stat_q <= `BTN_STAT_RESET;
            misc_stat_q <= `MISC_STAT_RESET;
            misc_mask_q <= `MISC_MASK_RESET;
            irq_out_n <= 1'b1;
            reg_rdata <= `RDATA_RESET;
        end
        else
        begin
            btn_mask_q <= btn_mask_d;
            btn_stat_q <= btn_stat_d;
            misc_stat_q <= misc_stat_d;
            misc_mask_q <= misc_mask;
            irq_out_n <= irq_n_d;
            reg_rdata <= rdata_d;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence fall_done_s;
        $past(deb_cnt_q) >= $past(debounce_fall_cycles);
    endsequence

    sequence rise_done_s;
        $past(deb_cnt_q) >= $past(debounce_rise_cycles);
    endsequence

    sequence host_idle_s;
        !reg_rd && !reg_wr;
    endsequence

    chk_irq_unmasked: assert property (|(btn_stat_q & ~btn_mask_q) |-> !irq_out_n)
        else $error("unmasked button flag did not pull irq low");
    chk_irq_masked: assert property
        ((btn_stat_q & ~btn_mask_q) == 6'h00 && (misc_stat_q & ~misc_mask_q) == 5'h00 |-> irq_out_n)
        else $error("irq low with no unmasked flag");
    chk_irq_or_all: assert property (|(misc_stat_q & ~misc_mask_q) |-> !irq_out_n)
        else $error("unmasked misc flag did not pull irq low");
    chk_mask_write: assert property
        (reg_wr && reg_addr == `ADDR_BTN_MASK |=> btn_mask_q == $past(reg_wdata[5:0]))
        else $error("button mask write lost");
    chk_debounce_path: assert property ($rose(press_q) |-> fall_done_s)
        else $error("press accepted without debounce");
    chk_release_debounce: assert property ($fell(press_q) |-> rise_done_s)
        else $error("release accepted without debounce");
    chk_release_clears: assert property (!press_q |-> sec_q == 4'h0 && held_q == 5'h00)
        else $error("held sense stays after release");
    chk_press_flag: assert property ($changed(press_q) |-> btn_stat_q[`BIT_PRESS])
        else $error("press sense change did not set flag");
    chk_held_flag: assert property ($rose(held_q[0]) |-> btn_stat_q[1])
        else $error("held flag not set");
    chk_misc_set: assert property (misc_evt != 5'h00 |=> (misc_stat_q & $past(misc_evt)) == $past(misc_evt))
        else $error("misc event lost");
    chk_misc_w1c: assert property
        (reg_wr && reg_addr == `ADDR_MISC_STAT && misc_evt == 5'h00
         |=> misc_stat_q == ($past(misc_stat_q) & ~$past(reg_wdata[4:0])))
        else $error("misc write-one-to-clear wrong");
    chk_misc_sticky: assert property
        (host_idle_s |=> (misc_stat_q & $past(misc_stat_q)) == $past(misc_stat_q))
        else $error("misc flag dropped without clear");
endmodule

`default_nettype wire

// ---- verification/host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_model
(
    input wire logic clk,
    output button_irq_pkg::reg_byte_t reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output button_irq_pkg::reg_byte_t reg_wdata,
    input wire button_irq_pkg::reg_byte_t reg_rdata
);
    import button_irq_pkg::*;
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // writing 1 clears a misc flag, 0 leaves it
    task automatic wr(input reg_byte_t a, input reg_byte_t d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    // a read of the misc status register also clears the misc flags
    task automatic rd(input reg_byte_t a, output reg_byte_t d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "button_irq_defs.svh"
module tb_top;
    import button_irq_pkg::*;
    localparam int unsigned SEC = 20;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic power_button_input = 1'b1;
    logic [15:0] deb = 16'h0004;
    logic [15:0] deb_r = 16'h0004;
    logic [4:0] v;
    int k;
    logic [4:0] ev = 5'h00;
    logic [4:0] mmask = 5'h1f;
    reg_byte_t addr, wdata, rdata, rv, m;
    logic wr, rd, irq_out_n;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int seed;
    host_model host_u (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata));
    button_and_power_event_irq #(.SEC_CYCLES(SEC), .DEB_W(16)) dut_u (.clk(clk), .resetn(resetn),
        .power_button_input(power_button_input), .debounce_fall_cycles(deb), .debounce_rise_cycles(deb_r),
        .misc_event_in(ev), .misc_mask(mmask), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdata), .reg_rdata(rdata), .irq_out_n(irq_out_n));
    initial
    begin
        forever #5 clk = ~clk;
    end
    function automatic reg_byte_t misc_bit(input int i);
        return 8'h01 << i;
    endfunction
    function automatic reg_byte_t mask_rb(input reg_byte_t v);
        return v & 8'h3f;
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input reg_byte_t exp, input reg_byte_t got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input string what, input reg_byte_t a, input reg_byte_t exp);
        host_u.rd(a, rv);
        chk(what, exp, rv);
    endtask
    task automatic ichk(input string what, input logic exp);
        chk(what, {7'h00, exp}, {7'h00, irq_out_n});
    endtask
    task automatic wait_c(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(input int i);
        ev[i] = 1'b1;
        wait_c(3);
        ev[i] = 1'b0;
        wait_c(5);
    endtask
    // hang guard, far above the few hundred cycles the tests use
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            end_sim();
        end
    end
    initial
    begin
        seed = $urandom(32'hd982);
        deb = 16'(3 + $urandom % 4);
        deb_r = 16'(3 + $urandom % 4);
        wait_c(10);
        resetn = 1'b1;
        wait_c(2);
        rchk("mask reset", `ADDR_BTN_MASK, 8'h3f);
        rchk("sense reset", `ADDR_BTN_SENSE, 8'h00);
        rchk("misc reset", `ADDR_MISC_STAT, 8'h00);
        rchk("unmapped", 8'h30, 8'h00);
        ichk("irq idle", 1'b1);
        $display("test reset done");
        for (int i = 0; i < 5; i++)
        begin
            mmask = ~(5'h01 << i);
            pulse(i);
            ichk("misc irq", 1'b0);
            host_u.wr(`ADDR_MISC_STAT, 8'h00);
            wait_c(2);
            ichk("misc w0", 1'b0);
            host_u.wr(`ADDR_MISC_STAT, misc_bit(i));
            wait_c(2);
            ichk("misc w1c", 1'b1);
            pulse(i);
            rchk("misc flag", `ADDR_MISC_STAT, misc_bit(i));
            rchk("misc rd clr", `ADDR_MISC_STAT, 8'h00);
        end
        // event and read strobe on one edge: the set must win
        k = int'($urandom % 5);
        ev[k] = 1'b1;
        wait_c(1);
        rchk("set wins rd", `ADDR_MISC_STAT, 8'h00);
        ev[k] = 1'b0;
        rchk("set wins flag", `ADDR_MISC_STAT, misc_bit(k));
        for (int j = 0; j < 4; j++)
        begin
            v = 5'($urandom);
            mmask = 5'($urandom);
            ev = v;
            wait_c(8);
            ichk("misc rand irq", ~|(v & ~mmask));
            ev = 5'h00;
            wait_c(5);
            rchk("misc rand flags", `ADDR_MISC_STAT, {3'b000, v});
        end
        mmask = 5'h1f;
        $display("test misc done");
        m = 8'($urandom);
        host_u.wr(`ADDR_BTN_MASK, m);
        rchk("mask rw", `ADDR_BTN_MASK, mask_rb(m));
        host_u.wr(`ADDR_BTN_SENSE, 8'hff);
        rchk("sense ro", `ADDR_BTN_SENSE, 8'h00);
        host_u.wr(`ADDR_BTN_MASK, 8'h3f);
        // glitch shorter than the debounce length
        power_button_input = 1'b0;
        wait_c(1);
        power_button_input = 1'b1;
        wait_c(20);
        rchk("glitch", `ADDR_BTN_SENSE, 8'h00);
        power_button_input = 1'b0;
        wait_c(int'(deb) + 10);
        rchk("press sense", `ADDR_BTN_SENSE, 8'h01);
        // release glitch shorter than the debounce length keeps the press
        power_button_input = 1'b1;
        wait_c(1);
        power_button_input = 1'b0;
        wait_c(3);
        rchk("release glitch", `ADDR_BTN_SENSE, 8'h01);
        wait_c(8 * SEC + 20);
        rchk("held sense", `ADDR_BTN_SENSE, 8'h3f);
        ichk("masked irq", 1'b1);
        host_u.wr(`ADDR_BTN_MASK, 8'h3d);
        ichk("held irq", 1'b0);
        rchk("btn status", `ADDR_BTN_STAT, 8'h3f);
        host_u.wr(`ADDR_BTN_MASK, 8'h3e);
        power_button_input = 1'b1;
        wait_c(int'(deb_r) + 10);
        rchk("release sense", `ADDR_BTN_SENSE, 8'h00);
        ichk("press irq", 1'b0);
        rchk("release flag", `ADDR_BTN_STAT, 8'h01);
        wait_c(2);
        ichk("irq release", 1'b1);
        $display("test button done");
        end_sim();
    end
endmodule
`default_nettype wire
